//--- logic/dcfc_fanout_ctrl.sv
`timescale 1ns/1ns
module dcfc_fanout_ctrl #(
  parameter int LOCK_CYC = dcfc_pkg::DRIVE_PD_CYC,
  parameter int OE_LAT   = dcfc_pkg::OE_LAT_DEF
) (
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  input  wire logic                             clk_en,
  input  wire logic                             ref_clock_a,
  input  wire logic                             ref_clock_b,
  input  wire logic                             input_select,
  input  wire logic                             power_good_powerdown,
  input  wire logic                             base_freq_strap,
  input  wire logic [1:0]                       bandwidth_mode_select,
  input  wire logic                             mgmt_addr_strap_hi,
  input  wire logic                             mgmt_addr_strap_lo,
  input  wire logic [14:5]                      pair_enable_n,
  input  wire logic                             group_low_enable_n,
  input  wire logic                             group_high_enable_n,
  input  wire logic                             smb_clk,
  input  wire logic                             smb_dat_in,
  output logic                                  smb_dat_out,
  output logic                                  smb_dat_oe,
  output logic [dcfc_pkg::NUM_PAIRS-1:0]        clock_out_true,
  output logic [dcfc_pkg::NUM_PAIRS-1:0]        clock_out_comp,
  output logic [dcfc_pkg::NUM_PAIRS-1:0]        clock_out_oe,
  output dcfc_pkg::dcfc_mode_s                  mode,
  output logic [2:0]                            freq_code,
  output logic                                  freq_code_reserved
);
  if (LOCK_CYC < 1 || LOCK_CYC > dcfc_pkg::DRIVE_PD_CYC || LOCK_CYC > dcfc_pkg::STAB_CYC) begin : g_chk
    $error("Lock time exceeds the drive limit.");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] mgmt_addr(input logic hi, input logic lo);
    mgmt_addr = dcfc_pkg::MGMT_ADDR_BASE + {5'h00, hi, lo};
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] idx, input logic [7:0] fsel);
    read_byte = (idx == dcfc_pkg::REG_FREQ_SELECT) ? fsel : 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Power sequencing, straps and the frequency byte
  // ----------------------------------------------------------------
  dcfc_pkg::dcfc_pwr_e   pwr_state;
  dcfc_pkg::dcfc_pwr_e   next_pwr_state;
  dcfc_pkg::dcfc_strap_s straps;
  dcfc_pkg::dcfc_strap_s next_straps;
  dcfc_pkg::dcfc_strap_s strap_in;
  dcfc_pkg::dcfc_mode_s  next_mode;
  logic [15:0]           lock_cnt;
  logic [15:0]           next_lock_cnt;
  logic [7:0]            freq_select;
  logic [7:0]            next_freq_select;
  logic                  next_reserved;
  logic                  pg_q;
  logic                  pg_rise;
  logic                  pg_fall;
  logic                  run;
  logic                  reg_wr;
  logic [7:0]            smb_shreg;

  assign strap_in = '{base_freq_strap, bandwidth_mode_select, mgmt_addr_strap_hi, mgmt_addr_strap_lo};
  assign pg_rise  = power_good_powerdown && !pg_q;
  assign pg_fall  = !power_good_powerdown && pg_q;
  assign run      = (pwr_state == dcfc_pkg::PWR_RUN);

  always_comb begin
    next_pwr_state   = pwr_state;
    next_lock_cnt    = lock_cnt;
    next_straps      = straps;
    next_freq_select = freq_select;
    if (reg_wr) begin
      next_freq_select = smb_shreg;
    end
    if (pg_fall) begin
      next_pwr_state = dcfc_pkg::PWR_DOWN;
    end else if (pg_rise) begin
      next_straps                               = strap_in;
      next_freq_select[dcfc_pkg::FREQ_STRAP_BIT] = base_freq_strap;
      next_pwr_state                            = dcfc_pkg::PWR_LOCK;
      next_lock_cnt                             = 16'(LOCK_CYC - 1);
    end else begin
      case (pwr_state)
        dcfc_pkg::PWR_LOCK: begin
          if (lock_cnt == 16'h0000) begin
            next_pwr_state = dcfc_pkg::PWR_RUN;
          end else begin
            next_lock_cnt = lock_cnt - 16'h0001;
          end
        end
        default: begin
        end
      endcase
    end
    next_mode.pll_on  = (pwr_state != dcfc_pkg::PWR_DOWN);
    next_mode.bypass  = (straps.bw_mode == dcfc_pkg::BW_BYPASS);
    next_mode.high_bw = (straps.bw_mode == dcfc_pkg::BW_HIGH);
    next_reserved     = (freq_select[2:0] == dcfc_pkg::FREQ_CODE_RESERVED);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_state          <= dcfc_pkg::PWR_DOWN;
      lock_cnt           <= 16'h0000;
      straps             <= '0;
      freq_select        <= dcfc_pkg::FREQ_SELECT_RESET;
      pg_q               <= 1'b0;
      mode               <= '0;
      freq_code_reserved <= 1'b0;
    end else if (clk_en) begin
      pwr_state          <= next_pwr_state;
      lock_cnt           <= next_lock_cnt;
      straps             <= next_straps;
      freq_select        <= next_freq_select;
      pg_q               <= power_good_powerdown;
      mode               <= next_mode;
      freq_code_reserved <= next_reserved;
    end
  end

  assign freq_code = freq_select[2:0];

  // ----------------------------------------------------------------
  // Management bus slave
  // ----------------------------------------------------------------
  // The bus pins are sampled as plain synchronous inputs, so the bus
  // clock must stay well below the system clock rate.
  dcfc_pkg::dcfc_smb_e   smb_state;
  dcfc_pkg::dcfc_smb_e   next_smb_state;
  dcfc_pkg::dcfc_stage_e stage;
  dcfc_pkg::dcfc_stage_e next_stage;
  logic [7:0]            next_smb_shreg;
  logic [7:0]            cmd_idx;
  logic [7:0]            next_cmd_idx;
  logic [7:0]            rd;
  logic [2:0]            bit_cnt;
  logic [2:0]            next_bit_cnt;
  logic                  byte_full;
  logic                  next_byte_full;
  logic                  next_oe;
  logic                  scl_q;
  logic                  sda_q;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  bus_start;
  logic                  bus_stop;

  assign scl_rise  = smb_clk && !scl_q;
  assign scl_fall  = !smb_clk && scl_q;
  assign bus_start = smb_clk && scl_q && sda_q && !smb_dat_in;
  assign bus_stop  = smb_clk && scl_q && !sda_q && smb_dat_in;
  assign rd        = read_byte(cmd_idx, freq_select);

  always_comb begin
    next_smb_state = smb_state;
    next_stage     = stage;
    next_smb_shreg = smb_shreg;
    next_cmd_idx   = cmd_idx;
    next_bit_cnt   = bit_cnt;
    next_byte_full = byte_full;
    next_oe        = smb_dat_oe;
    reg_wr         = 1'b0;
    if (bus_start) begin
      next_smb_state = dcfc_pkg::SMB_RX;
      next_stage     = dcfc_pkg::STG_ADDR;
      next_bit_cnt   = 3'h0;
      next_byte_full = 1'b0;
      next_oe        = 1'b0;
    end else if (bus_stop) begin
      next_smb_state = dcfc_pkg::SMB_IDLE;
      next_oe        = 1'b0;
    end else begin
      case (smb_state)
        dcfc_pkg::SMB_RX: begin
          if (scl_rise) begin
            next_smb_shreg = {smb_shreg[6:0], smb_dat_in};
            next_bit_cnt   = bit_cnt + 3'h1;
            next_byte_full = (bit_cnt == 3'h7);
          end else if (scl_fall && byte_full) begin
            next_byte_full = 1'b0;
            next_oe        = 1'b1;
            next_smb_state = dcfc_pkg::SMB_ACK;
            case (stage)
              dcfc_pkg::STG_ADDR: begin
                if (smb_shreg[7:1] != mgmt_addr(straps.addr_hi, straps.addr_lo)) begin
                  next_oe        = 1'b0;
                  next_smb_state = dcfc_pkg::SMB_IDLE;
                end
              end
              dcfc_pkg::STG_CMD: next_cmd_idx = smb_shreg;
              default: begin
                reg_wr       = (cmd_idx == dcfc_pkg::REG_FREQ_SELECT);
                next_cmd_idx = cmd_idx + 8'h01;
              end
            endcase
          end
        end
        dcfc_pkg::SMB_ACK: begin
          if (scl_fall) begin
            next_bit_cnt = 3'h0;
            if (stage == dcfc_pkg::STG_ADDR && smb_shreg[0]) begin
              next_smb_shreg = rd;
              next_oe        = !rd[7];
              next_smb_state = dcfc_pkg::SMB_TX;
            end else begin
              next_oe        = 1'b0;
              next_smb_state = dcfc_pkg::SMB_RX;
              next_stage     = (stage == dcfc_pkg::STG_ADDR) ? dcfc_pkg::STG_CMD : dcfc_pkg::STG_DATA;
            end
          end
        end
        dcfc_pkg::SMB_TX: begin
          if (scl_rise) begin
            next_bit_cnt   = bit_cnt + 3'h1;
            next_byte_full = (bit_cnt == 3'h7);
          end else if (scl_fall) begin
            if (byte_full) begin
              next_byte_full = 1'b0;
              next_oe        = 1'b0;
              next_smb_state = dcfc_pkg::SMB_TXACK;
            end else begin
              next_smb_shreg = {smb_shreg[6:0], 1'b0};
              next_oe        = !smb_shreg[6];
            end
          end
        end
        dcfc_pkg::SMB_TXACK: begin
          if (scl_rise) begin
            if (smb_dat_in) begin
              next_smb_state = dcfc_pkg::SMB_IDLE;
            end else begin
              next_byte_full = 1'b1;
              next_cmd_idx   = cmd_idx + 8'h01;
            end
          end else if (scl_fall && byte_full) begin
            next_byte_full = 1'b0;
            next_bit_cnt   = 3'h0;
            next_smb_shreg = rd;
            next_oe        = !rd[7];
            next_smb_state = dcfc_pkg::SMB_TX;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      smb_state   <= dcfc_pkg::SMB_IDLE;
      stage       <= dcfc_pkg::STG_ADDR;
      smb_shreg   <= 8'h00;
      cmd_idx     <= 8'h00;
      bit_cnt     <= 3'h0;
      byte_full   <= 1'b0;
      smb_dat_oe  <= 1'b0;
      smb_dat_out <= 1'b0;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
    end else if (clk_en) begin
      smb_state   <= next_smb_state;
      stage       <= next_stage;
      smb_shreg   <= next_smb_shreg;
      cmd_idx     <= next_cmd_idx;
      bit_cnt     <= next_bit_cnt;
      byte_full   <= next_byte_full;
      smb_dat_oe  <= next_oe;
      scl_q       <= smb_clk;
      sda_q       <= smb_dat_in;
    end
  end

  // ----------------------------------------------------------------
  // Reference select and output pairs
  // ----------------------------------------------------------------
  logic                          ref_sel;
  logic                          ref_q;
  logic                          ref_rise;
  logic                          ref_fall;
  logic [dcfc_pkg::NUM_PAIRS-1:0] gate_on;

  assign ref_sel  = input_select ? ref_clock_a : ref_clock_b;
  assign ref_rise = ref_sel && !ref_q;
  assign ref_fall = !ref_sel && ref_q;

  for (genvar i = 0; i < dcfc_pkg::NUM_PAIRS; i++) begin : g_pair
    logic req;
    if (i <= dcfc_pkg::GROUP_LOW_LAST) begin : g_lo
      assign req = !group_low_enable_n;
    end else if (i >= dcfc_pkg::GROUP_HIGH_FIRST) begin : g_hi
      assign req = !group_high_enable_n;
    end else begin : g_own
      assign req = !pair_enable_n[i];
    end
    dcfc_pair_gate #(.LAT(OE_LAT)) u_gate (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .run        (run),
      .enable_req (req),
      .ref_rise   (ref_rise),
      .ref_fall   (ref_fall),
      .gate_on    (gate_on[i])
    );
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_q          <= 1'b0;
      clock_out_true <= '0;
      clock_out_comp <= '0;
      clock_out_oe   <= '0;
    end else if (clk_en) begin
      ref_q          <= ref_sel;
      clock_out_true <= gate_on & {dcfc_pkg::NUM_PAIRS{ref_q}};
      clock_out_comp <= gate_on & {dcfc_pkg::NUM_PAIRS{!ref_q}};
      clock_out_oe   <= gate_on;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_fall_pd;
    (clk_en && pg_fall) |=> pwr_state == dcfc_pkg::PWR_DOWN ##1 (!clk_en || !mode.pll_on);
  endproperty
  a_fall_pd: assert property (p_fall_pd) else $error("No power-down after falling edge.");

  property p_pd_hiz;
    (clk_en && pwr_state == dcfc_pkg::PWR_DOWN) |-> ##2 (clock_out_oe == '0 || !$past(clk_en));
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("Pairs driven during power-down.");

  property p_strap;
    (clk_en && pg_rise) |=> straps == $past(strap_in);
  endproperty
  a_strap: assert property (p_strap) else $error("Straps not held at power-good.");

  property p_freq_bit2;
    (clk_en && pg_rise) |=> freq_code[2] == $past(base_freq_strap);
  endproperty
  a_freq_bit2: assert property (p_freq_bit2) else $error("Strap not in code bit 2.");

  property p_host_write;
    (clk_en && reg_wr && !pg_rise) |=> freq_code == $past(smb_shreg[2:0]);
  endproperty
  a_host_write: assert property (p_host_write) else $error("Host code not applied.");

  property p_mode;
    (clk_en && pg_rise) ##1 clk_en |=> mode.bypass == ($past(bandwidth_mode_select, 2) == 2'h1);
  endproperty
  a_mode: assert property (p_mode) else $error("Bypass mode wrong.");

  property p_addr;
    (smb_state == dcfc_pkg::SMB_ACK && stage == dcfc_pkg::STG_ADDR)
      |-> smb_shreg[7:1] == dcfc_pkg::MGMT_ADDR_BASE + {5'h00, straps.addr_hi, straps.addr_lo};
  endproperty
  a_addr: assert property (p_addr) else $error("Acked a foreign address.");

  property p_addr_hold;
    !pg_rise |=> $stable(straps.addr_hi) && $stable(straps.addr_lo);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("Address moved outside power-good.");

  property p_sel;
    ($past(clk_en) && $past(clk_en, 2) && clock_out_oe[5]) |-> clock_out_true[5] == $past(ref_sel, 2);
  endproperty
  a_sel: assert property (p_sel) else $error("Output not from selected input.");

  property p_groups;
    gate_on[4:0] == {5{gate_on[0]}} && gate_on[17:15] == {3{gate_on[15]}};
  endproperty
  a_groups: assert property (p_groups) else $error("Group pairs disagree.");

  property p_lock;
    $rose(run) |-> $past(lock_cnt) == 16'h0000 && $past(pwr_state) == dcfc_pkg::PWR_LOCK;
  endproperty
  a_lock: assert property (p_lock) else $error("Run entered before lock count.");

  c_run: cover property ($rose(run));
  c_write: cover property (reg_wr);
  c_read: cover property (smb_state == dcfc_pkg::SMB_TX);
  c_start: cover property ($rose(clock_out_oe[0]));
endmodule

//--- logic/dcfc_pair_gate.sv
`timescale 1ns/1ns
module dcfc_pair_gate #(
  parameter int LAT = dcfc_pkg::OE_LAT_DEF
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic run,
  input  wire logic enable_req,
  input  wire logic ref_rise,
  input  wire logic ref_fall,
  output logic      gate_on
);
  if (LAT < dcfc_pkg::OE_LAT_MIN || LAT > dcfc_pkg::OE_LAT_MAX - 1) begin : g_chk
    $error("Enable latency out of range.");
  end

  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       next_gate;

  // Enable changes land on a falling reference edge so no runt pulse leaves; loss of run clears the gate at once.
  always_comb begin
    next_cnt  = cnt;
    next_gate = gate_on;
    if (!run) begin
      next_gate = 1'b0;
      next_cnt  = 4'h0;
    end else if (enable_req == gate_on) begin
      next_cnt = 4'h0;
    end else if (cnt < 4'(LAT)) begin
      if (ref_rise) begin
        next_cnt = cnt + 4'h1;
      end
    end else if (ref_fall) begin
      next_gate = enable_req;
      next_cnt  = 4'h0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt     <= 4'h0;
      gate_on <= 1'b0;
    end else if (clk_en) begin
      cnt     <= next_cnt;
      gate_on <= next_gate;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_lat_apply;
    (clk_en && run && ref_fall && cnt == 4'(LAT) && enable_req != gate_on) |=> gate_on == $past(enable_req);
  endproperty
  a_lat_apply: assert property (p_lat_apply) else $error("Enable change not applied.");

  property p_edge_only;
    (run && $changed(gate_on)) |-> $past(ref_fall) && $past(cnt) == 4'(LAT);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("Gate moved off a falling edge.");

  property p_off;
    (clk_en && !run) |=> !gate_on;
  endproperty
  a_off: assert property (p_off) else $error("Gate open while not running.");
endmodule

//--- logic/dcfc_pkg.sv
package dcfc_pkg;
  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int NUM_PAIRS        = 18;
  localparam int CLK_MHZ          = 50;
  localparam int DRIVE_PD_US      = 300;
  localparam int DRIVE_PD_CYC     = DRIVE_PD_US * CLK_MHZ;
  localparam int STAB_MS          = 1;
  localparam int STAB_CYC         = STAB_MS * 1000 * CLK_MHZ;
  localparam int OE_LAT_MIN       = 4;
  localparam int OE_LAT_MAX       = 12;
  localparam int OE_LAT_DEF       = 5;
  localparam int GROUP_LOW_LAST   = 4;
  localparam int GROUP_HIGH_FIRST = 15;

  // ----------------------------------------------------------------
  // Registers and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_FREQ_SELECT    = 8'h00;
  localparam logic [7:0] FREQ_SELECT_RESET  = 8'h05;
  localparam int         FREQ_STRAP_BIT     = 2;
  localparam logic [2:0] FREQ_CODE_RESERVED = 3'h7;
  localparam logic [6:0] MGMT_ADDR_BASE     = 7'h6A;
  localparam logic [1:0] BW_LOW             = 2'h0;
  localparam logic [1:0] BW_BYPASS          = 2'h1;
  localparam logic [1:0] BW_HIGH            = 2'h2;

  typedef enum logic [1:0] {PWR_DOWN, PWR_LOCK, PWR_RUN} dcfc_pwr_e;
  typedef enum logic [2:0] {SMB_IDLE, SMB_RX, SMB_ACK, SMB_TX, SMB_TXACK} dcfc_smb_e;
  typedef enum logic [1:0] {STG_ADDR, STG_CMD, STG_DATA} dcfc_stage_e;

  typedef struct packed {
    logic       base_freq;
    logic [1:0] bw_mode;
    logic       addr_hi;
    logic       addr_lo;
  } dcfc_strap_s;

  typedef struct packed {
    logic pll_on;
    logic bypass;
    logic high_bw;
  } dcfc_mode_s;
endpackage

//--- sim/dcfc_ref_src.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Reference generator
// ----------------------------------------------------------------
// The two references run at unequal rates so the selected one can be told apart.
module dcfc_ref_src #(
  parameter int HALF_A = 4,
  parameter int HALF_B = 6
) (
  input  wire logic clk,
  output logic      ref_a,
  output logic      ref_b
);
  int   cnt_a = 0;
  int   cnt_b = 0;
  logic ra    = 1'h0;
  logic rb    = 1'h0;
  assign ref_a = ra;
  assign ref_b = rb;
  always @(negedge clk) begin
    cnt_a <= (cnt_a + 1) % HALF_A;
    cnt_b <= (cnt_b + 1) % HALF_B;
    if (cnt_a == HALF_A - 1)
      ra <= ~ra;
    if (cnt_b == HALF_B - 1)
      rb <= ~rb;
  end
endmodule

//--- sim/test_dcfc_fanout_ctrl.sv
`timescale 1ns/1ns
module test_diff_clock_fanout_control;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic                 clk;
  logic                 sys_rst = 1'h1;
  logic                 en = 1'h1;
  logic                 ref_a;
  logic                 ref_b;
  logic                 sel = 1'h1;
  logic                 pg = 1'h0;
  logic                 base = 1'h0;
  logic [1:0]           bw = 2'h0;
  logic                 a_hi = 1'h0;
  logic                 a_lo = 1'h0;
  logic [14:5]          pair_n = 10'h3FF;
  logic                 grp_lo_n = 1'h0;
  logic                 grp_hi_n = 1'h1;
  logic                 scl = 1'h1;
  logic                 sda_h = 1'h1;
  logic                 dat_out;
  logic                 dat_oe;
  logic [17:0]          ck_t;
  logic [17:0]          ck_c;
  logic [17:0]          ck_oe;
  dcfc_pkg::dcfc_mode_s mode;
  logic [2:0]           code;
  logic                 resv;
  int                   errors = 0;
  int                   samples_checked = 0;
  // Open-drain data wire: the device can only pull it low.
  wire                  sda_in = sda_h & ~(dat_oe & ~dat_out);

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  dcfc_ref_src ref_gen (.clk(clk), .ref_a(ref_a), .ref_b(ref_b));
  dcfc_fanout_ctrl #(.LOCK_CYC(20)) dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(en), .ref_clock_a(ref_a), .ref_clock_b(ref_b),
    .input_select(sel), .power_good_powerdown(pg), .base_freq_strap(base), .bandwidth_mode_select(bw),
    .mgmt_addr_strap_hi(a_hi), .mgmt_addr_strap_lo(a_lo), .pair_enable_n(pair_n),
    .group_low_enable_n(grp_lo_n), .group_high_enable_n(grp_hi_n), .smb_clk(scl), .smb_dat_in(sda_in),
    .smb_dat_out(dat_out), .smb_dat_oe(dat_oe), .clock_out_true(ck_t), .clock_out_comp(ck_c),
    .clock_out_oe(ck_oe), .mode(mode), .freq_code(code), .freq_code_reserved(resv));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Each bus phase lasts four system clocks, above the three the sampler needs.
  task automatic bit_io(input logic b, output logic r);
    sda_h = b;
    w(4);
    scl = 1'h1;
    w(4);
    r = sda_in;
    scl = 1'h0;
    w(4);
  endtask
  task automatic byte_io(input logic [7:0] d, output logic ack);
    logic r;
    for (int k = 7; k >= 0; k--)
      bit_io(d[k], r);
    bit_io(1'h1, ack);
  endtask
  task automatic bus_write(input logic [6:0] adr, input logic [7:0] d, input logic exp_ack);
    logic a;
    logic x;
    sda_h = 1'h0;
    w(4);
    scl = 1'h0;
    byte_io({adr, 1'h0}, a);
    byte_io(8'h00, x);
    byte_io(d, x);
    sda_h = 1'h0;
    w(4);
    scl = 1'h1;
    w(4);
    sda_h = 1'h1;
    w(4);
    chk("address ack", 18'(exp_ack), 18'(a));
  endtask
  // Write the index, then a repeated start and one read byte closed by a no-acknowledge.
  task automatic bus_read(input logic [6:0] adr, output logic [7:0] d);
    logic x;
    sda_h = 1'h0;
    w(4);
    scl = 1'h0;
    byte_io({adr, 1'h0}, x);
    byte_io(8'h00, x);
    sda_h = 1'h1;
    w(4);
    scl = 1'h1;
    w(4);
    sda_h = 1'h0;
    w(4);
    scl = 1'h0;
    byte_io({adr, 1'h1}, x);
    for (int k = 7; k >= 0; k--)
      bit_io(1'h1, d[k]);
    bit_io(1'h1, x);
    sda_h = 1'h0;
    w(4);
    scl = 1'h1;
    w(4);
    sda_h = 1'h1;
    w(4);
  endtask
  task automatic power_up;
    pg = 1'h1;
    for (int k = 0; k < 200 && ck_oe[0] !== 1'h1; k++)
      w(1);
    w(4);
  endtask
  task automatic toggles(output int n);
    logic p;
    n = 0;
    p = ck_t[0];
    repeat (48) begin
      w(1);
      if (ck_t[0] !== p)
        n++;
      p = ck_t[0];
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic strap_cycle(input int i);
    logic [2:0] m;
    logic [7:0] rdv;
    m = (i == 1) ? 3'h6 : (i == 2) ? 3'h5 : 3'h4;
    {base, bw, a_hi, a_lo} = {i[0], i[1:0], i[1:0]};
    pg = 1'h1;
    w(4);
    chk("strap bit", 18'(base), 18'(code[2]));
    chk("mode", 18'(m), 18'(mode));
    power_up();
    chk("drive", 18'h0001F, ck_oe);
    chk("complement", ck_oe, (ck_t ^ ck_c) & ck_oe);
    bus_write(7'h6A + 7'(i), 8'(2 * i + 1), 1'h0);
    chk("code", 18'(2 * i + 1), 18'(code));
    chk("reserved", 18'(i == 3), 18'(resv));
    bus_read(7'h6A + 7'(i), rdv);
    chk("read byte", 18'(2 * i + 1), 18'(rdv));
    bus_write(7'h6A + 7'((i + 1) % 4), 8'h02, 1'h1);
    chk("code kept", 18'(2 * i + 1), 18'(code));
    pg = 1'h0;
    w(4);
    chk("down drive", 18'h00000, ck_oe);
    chk("down pll", 18'h00000, 18'(mode.pll_on));
  endtask
  // A single pair's enable must wait several whole reference cycles.
  task automatic enable_latency;
    int n;
    power_up();
    pair_n[5] = 1'h0;
    w(32);
    chk("early", 18'h00000, 18'(ck_oe[5]));
    for (int k = 0; k < 70 && ck_oe[5] !== 1'h1; k++)
      w(1);
    chk("late", 18'h00001, 18'(ck_oe[5]));
    grp_hi_n = 1'h0;
    w(120);
    chk("group high", 18'h3803F, ck_oe);
    toggles(n);
    chk("ref a", 18'h0000C, 18'(n));
    sel = 1'h0;
    w(8);
    toggles(n);
    chk("ref b", 18'h00008, 18'(n));
    en = 1'h0;
    toggles(n);
    chk("frozen", 18'h00000, 18'(n));
    en = 1'h1;
    pair_n[5] = 1'h1;
    w(44);
    chk("stop early", 18'h00001, 18'(ck_oe[5]));
    w(36);
    chk("stop late", 18'h00000, 18'(ck_oe[5]));
  endtask

  initial begin
    w(4);
    sys_rst = 1'h0;
    w(2);
    chk("reset code", 18'h00005, 18'(code));
    chk("reset drive", 18'h00000, ck_oe);
    for (int i = 0; i < 4; i++)
      strap_cycle(i);
    enable_latency();
    summarize();
  end
  initial begin
    w(12000);
    errors++;
    summarize();
  end
endmodule
